// *** design/rtcev_detect.sv ***
// Purpose: Samples and filters the synchronised event level.
// Assumes: level is already synchronised to clk.
// Notes: detect is a one-cycle pulse on each qualified rising level.
`timescale 1ns/100ps
module rtcev_detect #(
   parameter int SAMP1_CYC = rtcev_pkg::SAMP1_CYC,
   parameter int SAMP2_CYC = rtcev_pkg::SAMP2_CYC,
   parameter int SAMP3_CYC = rtcev_pkg::SAMP3_CYC,
   parameter int HYS0 = rtcev_pkg::HYS0_SMP,
   parameter int HYS1 = rtcev_pkg::HYS1_SMP,
   parameter int HYS2 = rtcev_pkg::HYS2_SMP,
   parameter int HYS3 = rtcev_pkg::HYS3_SMP,
   parameter int DIV_W = 15
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic level,
   input wire logic enable,
   input wire logic [1:0] samp_sel,
   input wire logic [1:0] hys_sel,
   output logic detect
);

   typedef struct packed
   {
      logic [DIV_W-1:0] div;
      logic [3:0] persist;
      logic filt;
      logic det;
   } rtcev_det_t;

   rtcev_det_t s_reg;
   rtcev_det_t s_next;
   logic tick;
   logic [DIV_W-1:0] period;
   logic [3:0] need;

   always_comb
   begin
      case (samp_sel)
         2'h1: period = DIV_W'(SAMP1_CYC - 1);
         2'h2: period = DIV_W'(SAMP2_CYC - 1);
         default: period = DIV_W'(SAMP3_CYC - 1);
      endcase
      case (hys_sel)
         2'h0: need = 4'(HYS0);
         2'h1: need = 4'(HYS1);
         2'h2: need = 4'(HYS2);
         default: need = 4'(HYS3);
      endcase
      tick = (s_reg.div >= period);
      s_next = s_reg;
      s_next.div = tick ? '0 : s_reg.div + 1'b1;
      if (!enable)
      begin
         s_next.div = '0;
         s_next.persist = 4'h0;
         s_next.filt = 1'b0;
      end
      else if (samp_sel == 2'h0)
      begin
         // Without sampling the filter is bypassed.
         s_next.persist = 4'h0;
         s_next.filt = level;
      end
      else if (tick)
      begin
         if (level)
         begin
            if (s_reg.persist < need)
               s_next.persist = s_reg.persist + 4'h1;
            s_next.filt = (s_reg.persist + 4'h1 >= need);
         end
         else
         begin
            s_next.persist = 4'h0;
            s_next.filt = 1'b0;
         end
      end
      s_next.det = s_next.filt & ~s_reg.filt;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign detect = s_reg.det;

   raw_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
      (enable && samp_sel == 2'h0 && level && !s_reg.filt) |=> detect)
      else $error("Unsampled high level was not detected.");

   sampled_high_a: assert property (@(posedge clk) disable iff (!arst_n)
      (detect && $past(samp_sel) != 2'h0) |-> $past(level))
      else $error("Detection without a high sample.");

endmodule

// *** design/rtcev_event_stamp.sv ***
// Purpose: Event detection, flag, timestamp and counter halt, with a
//          two-wire serial slave for the register map.
// Assumes: scl_pin, sda_in, event_input and battery_mode are asynchronous.
// Notes: The clock counters sit outside and are reached via time_now,
//        clock_write and counter_halt.
`timescale 1ns/100ps
module rtcev_event_stamp #(
   parameter logic [6:0] DEV_ADDR = rtcev_pkg::DEV_ADDR_DEFAULT,
   parameter int SAMP3_CYC = rtcev_pkg::SAMP3_CYC
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic scl_pin,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic event_input,
   input wire logic battery_mode,
   input wire rtcev_pkg::rtcev_bytes_t time_now,
   output logic counter_halt,
   output logic pull_enable,
   output rtcev_pkg::rtcev_wr_t clock_write
);

   typedef struct packed
   {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic [1:0] ev_s;
      logic [1:0] bat_s;
      logic scl_q;
      logic sda_q;
      rtcev_pkg::rtcev_bus_st_t st;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic rw;
      logic ack;
      logic [7:0] ptr;
      logic [7:0] rd_byte;
      logic sda_drv;
      logic sda_oe;
      logic flag;
      logic [7:0] cfg;
      logic halt;
      logic pull_en;
      rtcev_pkg::rtcev_wr_t cw;
   } rtcev_top_t;

   localparam rtcev_top_t TOP_RESET = '{
      st: rtcev_pkg::RTCEV_IDLE,
      cfg: rtcev_pkg::CFG_RESET,
      pull_en: ~rtcev_pkg::CFG_RESET[rtcev_pkg::CFG_PULL_BIT],
      scl_s: 2'h3,
      sda_s: 2'h3,
      scl_q: 1'b1,
      sda_q: 1'b1,
      default: '0
   };

   rtcev_top_t s_reg;
   rtcev_top_t s_next;
   rtcev_pkg::rtcev_bytes_t stamp;
   logic detect;
   logic capture;
   logic sample_en;
   logic scl;
   logic sda;
   logic scl_rise;
   logic bus_start;
   logic bus_stop;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;

   function automatic logic in_range(input logic [7:0] a,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [7:0] reg_read(input logic [7:0] a);
      reg_read = 8'h00;
      if (in_range(a, rtcev_pkg::ADDR_TIME_FIRST, rtcev_pkg::ADDR_TIME_LAST))
         reg_read = time_now[3'(a - rtcev_pkg::ADDR_TIME_FIRST)];
      else if (in_range(a, rtcev_pkg::ADDR_STAMP_FIRST,
                        rtcev_pkg::ADDR_STAMP_LAST))
         reg_read = stamp[3'(a - rtcev_pkg::ADDR_STAMP_FIRST)];
      else if (a == rtcev_pkg::ADDR_STATUS)
         reg_read[rtcev_pkg::STAT_FLAG_BIT] = s_reg.flag;
      else if (a == rtcev_pkg::ADDR_CFG)
         reg_read = s_reg.cfg;
   endfunction

   // Sampling stays live in backup unless software opts out.
   assign sample_en = ~(s_reg.bat_s[1] & s_reg.cfg[rtcev_pkg::CFG_BKUP_BIT]);
   // The first event of a series owns the stamp.
   assign capture = detect & ~s_reg.flag;

   rtcev_detect #(
      .SAMP3_CYC(SAMP3_CYC)
   ) u_detect (
      .clk(clk),
      .arst_n(arst_n),
      .level(s_reg.ev_s[1]),
      .enable(sample_en),
      .samp_sel(s_reg.cfg[rtcev_pkg::CFG_SAMP_LSB +: 2]),
      .hys_sel(s_reg.cfg[rtcev_pkg::CFG_HYS_LSB +: 2]),
      .detect(detect)
   );

   rtcev_stamp u_stamp (
      .clk(clk),
      .arst_n(arst_n),
      .capture(capture),
      .time_now(time_now),
      .stamp(stamp)
   );

   assign scl = s_reg.scl_s[1];
   assign sda = s_reg.sda_s[1];
   assign scl_rise = scl & ~s_reg.scl_q;
   assign bus_start = scl & s_reg.scl_q & s_reg.sda_q & ~sda;
   assign bus_stop = scl & s_reg.scl_q & ~s_reg.sda_q & sda;

   always_comb
   begin
      s_next = s_reg;
      s_next.cw.wr = 1'b0;
      wr_en = 1'b0;
      wr_addr = s_reg.ptr;
      wr_data = {s_reg.shift[6:0], sda};
      s_next.scl_s = {s_reg.scl_s[0], scl_pin};
      s_next.sda_s = {s_reg.sda_s[0], sda_in};
      s_next.ev_s = {s_reg.ev_s[0], event_input};
      s_next.bat_s = {s_reg.bat_s[0], battery_mode};
      s_next.scl_q = scl;
      s_next.sda_q = sda;

      if (bus_start)
      begin
         s_next.st = rtcev_pkg::RTCEV_ADDR;
         s_next.cnt = 4'h0;
         s_next.ack = 1'b0;
         s_next.sda_oe = 1'b0;
      end
      else if (bus_stop)
      begin
         s_next.st = rtcev_pkg::RTCEV_IDLE;
         s_next.ack = 1'b0;
         s_next.sda_oe = 1'b0;
      end
      else if (s_reg.st != rtcev_pkg::RTCEV_IDLE)
      begin
         if (scl_rise && s_reg.cnt != 4'h8)
         begin
            s_next.shift = {s_reg.shift[6:0], sda};
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == 4'h7)
            begin
               case (s_reg.st)
                  rtcev_pkg::RTCEV_ADDR:
                  begin
                     if (s_reg.shift[6:0] == DEV_ADDR)
                     begin
                        s_next.ack = 1'b1;
                        s_next.rw = sda;
                     end
                     else
                        s_next.st = rtcev_pkg::RTCEV_IDLE;
                  end
                  rtcev_pkg::RTCEV_REGA:
                  begin
                     s_next.ack = 1'b1;
                     s_next.ptr = wr_data;
                  end
                  rtcev_pkg::RTCEV_WDAT:
                  begin
                     s_next.ack = 1'b1;
                     wr_en = 1'b1;
                     s_next.ptr = s_reg.ptr + 8'h01;
                  end
                  default:
                  begin
                  end
               endcase
            end
         end
         else if (scl_rise)
         begin
            s_next.cnt = 4'h0;
            s_next.ack = 1'b0;
            case (s_reg.st)
               rtcev_pkg::RTCEV_ADDR:
               begin
                  if (s_reg.rw)
                  begin
                     s_next.st = rtcev_pkg::RTCEV_RDAT;
                     s_next.rd_byte = reg_read(s_reg.ptr);
                  end
                  else
                     s_next.st = rtcev_pkg::RTCEV_REGA;
               end
               rtcev_pkg::RTCEV_REGA:
                  s_next.st = rtcev_pkg::RTCEV_WDAT;
               rtcev_pkg::RTCEV_RDAT:
               begin
                  // A master acknowledge asks for the next address.
                  if (sda)
                     s_next.st = rtcev_pkg::RTCEV_IDLE;
                  else
                  begin
                     s_next.ptr = s_reg.ptr + 8'h01;
                     s_next.rd_byte = reg_read(s_reg.ptr + 8'h01);
                  end
               end
               default:
               begin
               end
            endcase
         end
         if (~scl & s_reg.scl_q)
         begin
            if (s_reg.cnt == 4'h8)
               s_next.sda_oe = s_reg.ack;
            else
               s_next.sda_oe = (s_reg.st == rtcev_pkg::RTCEV_RDAT) &
                               ~s_reg.rd_byte[3'(4'h7 - s_reg.cnt)];
         end
      end

      // Register writes; stamp bytes have no write path at all.
      if (wr_en)
      begin
         if (wr_addr == rtcev_pkg::ADDR_STATUS &&
             !wr_data[rtcev_pkg::STAT_FLAG_BIT])
            s_next.flag = 1'b0;
         if (wr_addr == rtcev_pkg::ADDR_CFG)
            s_next.cfg = wr_data & rtcev_pkg::CFG_WMASK;
         if (in_range(wr_addr, rtcev_pkg::ADDR_TIME_FIRST,
                      rtcev_pkg::ADDR_TIME_LAST))
         begin
            s_next.cw.wr = 1'b1;
            s_next.cw.addr = wr_addr;
            s_next.cw.data = wr_data;
            s_next.halt = 1'b0;
         end
      end

      // Event handling comes last so a coincident set beats a clear.
      if (detect)
      begin
         s_next.flag = 1'b1;
         if (s_reg.cfg[rtcev_pkg::CFG_HALT_BIT])
            s_next.halt = 1'b1;
      end
      s_next.pull_en = ~s_next.cfg[rtcev_pkg::CFG_PULL_BIT];
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         s_reg <= TOP_RESET;
      else
         s_reg <= s_next;
   end

   assign sda_out = s_reg.sda_drv;
   assign sda_oe = s_reg.sda_oe;
   assign counter_halt = s_reg.halt;
   assign pull_enable = s_reg.pull_en;
   assign clock_write = s_reg.cw;

   first_kept_a: assert property (@(posedge clk) disable iff (!arst_n)
      (s_reg.flag && detect) |=> $stable(stamp))
      else $error("Later event overwrote the first timestamp.");

   flag_set_a: assert property (@(posedge clk) disable iff (!arst_n)
      detect |=> s_reg.flag)
      else $error("Event did not set the flag.");

   rearm_capture_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!s_reg.flag && detect) |=> (stamp == $past(time_now)) && s_reg.flag)
      else $error("Re-armed event did not capture the time.");

   halt_event_a: assert property (@(posedge clk) disable iff (!arst_n)
      (detect && s_reg.cfg[rtcev_pkg::CFG_HALT_BIT]) |=> counter_halt)
      else $error("Event did not halt the counters.");

   no_halt_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!counter_halt && !(detect && s_reg.cfg[rtcev_pkg::CFG_HALT_BIT]))
      |=> !counter_halt)
      else $error("Counters halted without a qualifying event.");

   resume_write_a: assert property (@(posedge clk) disable iff (!arst_n)
      (counter_halt && wr_en && !detect &&
       in_range(wr_addr, rtcev_pkg::ADDR_TIME_FIRST,
                rtcev_pkg::ADDR_TIME_LAST))
      |=> !counter_halt && clock_write.wr)
      else $error("Time write did not resume counting.");

   backup_block_a: assert property (@(posedge clk) disable iff (!arst_n)
      (s_reg.bat_s[1] && s_reg.cfg[rtcev_pkg::CFG_BKUP_BIT]) [*2]
      |=> !detect)
      else $error("Event detected while backup sampling is disabled.");

   flag_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_en && wr_addr == rtcev_pkg::ADDR_STATUS &&
       !wr_data[rtcev_pkg::STAT_FLAG_BIT] && !detect) |=> !s_reg.flag)
      else $error("Writing zero did not clear the flag.");

   pull_ctl_a: assert property (@(posedge clk) disable iff (!arst_n)
      $changed(s_reg.cfg) |-> ##[0:1]
      (pull_enable == !s_reg.cfg[rtcev_pkg::CFG_PULL_BIT]))
      else $error("Pull source does not follow its control bit.");

   stop_release_a: assert property (@(posedge clk) disable iff (!arst_n)
      bus_stop |=> !sda_oe && s_reg.st == rtcev_pkg::RTCEV_IDLE)
      else $error("Stop condition did not release the bus.");

   event_seen_c: cover property (@(posedge clk) disable iff (!arst_n)
      capture);
   halt_seen_c: cover property (@(posedge clk) disable iff (!arst_n)
      $rose(counter_halt));
   stamp_read_c: cover property (@(posedge clk) disable iff (!arst_n)
      scl_rise && s_reg.st == rtcev_pkg::RTCEV_RDAT && s_reg.cnt == 4'h8
      && s_reg.ptr == rtcev_pkg::ADDR_STAMP_LAST);
   flag_clear_c: cover property (@(posedge clk) disable iff (!arst_n)
      $fell(s_reg.flag));

endmodule

// *** design/rtcev_pkg.sv ***
// Purpose: Shared constants and types for the event timestamp block.
// Assumes: 25 MHz system clock; 8-bit register map on the serial bus.
// Notes: Sample periods and hysteresis counts are defaults only.
package rtcev_pkg;

   localparam int CLK_PERIOD_NS = 40;

   // Register map.
   localparam logic [7:0] ADDR_TIME_FIRST = 8'h00;
   localparam logic [7:0] ADDR_TIME_LAST = 8'h05;
   localparam logic [7:0] ADDR_STATUS = 8'h07;
   localparam logic [7:0] ADDR_CFG = 8'h09;
   localparam logic [7:0] ADDR_STAMP_FIRST = 8'h14;
   localparam logic [7:0] ADDR_STAMP_LAST = 8'h19;

   // Field positions.
   localparam int STAT_FLAG_BIT = 4;
   localparam int CFG_HYS_LSB = 0;
   localparam int CFG_SAMP_LSB = 2;
   localparam int CFG_HALT_BIT = 5;
   localparam int CFG_BKUP_BIT = 6;
   localparam int CFG_PULL_BIT = 7;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CFG_WMASK = 8'hef;

   // Bus address of the device; the value is arbitrary.
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5a;

   // Sample periods for codes 1 to 3; code 0 bypasses sampling and the filter.
   localparam int SAMP1_US = 10;
   localparam int SAMP2_US = 100;
   localparam int SAMP3_US = 1000;
   localparam int SAMP1_CYC = (SAMP1_US * 1000) / CLK_PERIOD_NS;
   localparam int SAMP2_CYC = (SAMP2_US * 1000) / CLK_PERIOD_NS;
   localparam int SAMP3_CYC = (SAMP3_US * 1000) / CLK_PERIOD_NS;

   // Consecutive high samples needed for each hysteresis code.
   localparam int HYS0_SMP = 1;
   localparam int HYS1_SMP = 2;
   localparam int HYS2_SMP = 4;
   localparam int HYS3_SMP = 8;

   localparam int NUM_TIME_BYTES = 6;
   typedef logic [NUM_TIME_BYTES-1:0][7:0] rtcev_bytes_t;

   typedef enum logic [4:0]
   {
      RTCEV_IDLE = 5'h01,
      RTCEV_ADDR = 5'h02,
      RTCEV_REGA = 5'h04,
      RTCEV_WDAT = 5'h08,
      RTCEV_RDAT = 5'h10
   } rtcev_bus_st_t;

   typedef struct packed
   {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } rtcev_wr_t;

endpackage

// *** design/rtcev_stamp.sv ***
// Purpose: Holds the captured clock and calendar bytes.
// Assumes: capture is a one-cycle pulse on clk.
// Notes: No reset; contents survive everything except loss of power.
`timescale 1ns/100ps
module rtcev_stamp (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic capture,
   input wire rtcev_pkg::rtcev_bytes_t time_now,
   output rtcev_pkg::rtcev_bytes_t stamp
);

   typedef struct packed
   {
      rtcev_pkg::rtcev_bytes_t bytes;
   } rtcev_stamp_t;

   rtcev_stamp_t s_reg;
   rtcev_stamp_t s_next;

   always_comb
   begin
      s_next = s_reg;
      if (capture)
         s_next.bytes = time_now;
   end

   // Reset is deliberately not applied: only power loss may erase it.
   always_ff @(posedge clk)
   begin
      s_reg <= s_next;
   end

   assign stamp = s_reg.bytes;

   stamp_load_a: assert property (@(posedge clk) disable iff (!arst_n)
      capture |=> (stamp == $past(time_now)))
      else $error("Timestamp did not load the current time.");

   stamp_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!capture && $past(!capture)) |=> $stable(stamp))
      else $error("Timestamp changed without a capture.");

endmodule

// *** tb/rtcev_host_model.sv ***
// Purpose: Host side of the two-wire register bus, a behavioural master.
// Assumes: The wire has a pull-up, so a released line reads high.
// Notes: Half periods are HP clk cycles; the device never stretches SCL.
`timescale 1ns/100ps
module rtcev_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h33
)(
   input wire logic clk,
   input wire logic dev_oe,
   output logic scl,
   output logic sda_wire
);
   localparam int HP = 8;
   logic drv_low = 1'b0;
   initial scl = 1'b1;
   // Wired-AND of both parties; the pull-up wins when nobody pulls.
   assign sda_wire = !(drv_low | dev_oe);

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic clk_bit(input logic b, output logic s);
      drv_low = !b;
      tick(HP);
      scl = 1'b1;
      s = sda_wire;
      tick(HP);
      scl = 1'b0;
   endtask

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                       input logic ack_tx);
      logic ack_n;
      for (int i = 7; i >= 0; i--)
         clk_bit(tx[i], rx[i]);
      clk_bit(ack_tx, ack_n);
   endtask

   task automatic start();
      drv_low = 1'b0;
      tick(HP);
      scl = 1'b1;
      tick(HP);
      drv_low = 1'b1;
      tick(HP);
      scl = 1'b0;
   endtask

   task automatic stop();
      drv_low = 1'b1;
      tick(HP);
      scl = 1'b1;
      tick(HP);
      drv_low = 1'b0;
      tick(HP);
   endtask

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] rx;
      start();
      xfer({DEV_ADDR, 1'b0}, rx, 1'b1);
      xfer(a, rx, 1'b1);
      xfer(d, rx, 1'b1);
      stop();
   endtask

   // The last byte gets a NACK so the device lets go of the wire.
   task automatic read_regs(input logic [7:0] a, input int n,
                            output rtcev_pkg::rtcev_bytes_t v);
      logic [7:0] rx;
      start();
      xfer({DEV_ADDR, 1'b0}, rx, 1'b1);
      xfer(a, rx, 1'b1);
      start();
      xfer({DEV_ADDR, 1'b1}, rx, 1'b1);
      for (int i = 0; i < n; i++)
         xfer(8'hff, v[i], (i == n - 1));
      stop();
   endtask
endmodule

// *** tb/tb_rtcev_event_stamp.sv ***
// Purpose: Self-checking bench for the event timestamp block.
// Assumes: Bus traffic comes from the host model; results are queued.
// Notes: The slowest sample period is cut to 50 clk to keep runs short.
`timescale 1ns/100ps
module tb_rtcev_event_stamp;
   localparam logic [6:0] DA = 7'h33; // Arbitrary bus address.
   logic clk, arst_n, event_input, battery_mode, scl, sda;
   logic sda_out, sda_oe, counter_halt, pull_enable;
   rtcev_pkg::rtcev_bytes_t time_now, rb, t1, t2, t3;
   rtcev_pkg::rtcev_wr_t clock_write;
   logic [16:0] note_q[$];
   string name_q[$];
   logic [16:0] seen_v;
   event seen_ev;
   logic [7:0] c;
   int miscompares = 0;
   int compares = 0;

   rtcev_event_stamp #(.DEV_ADDR(DA), .SAMP3_CYC(50)) DUT (.clk(clk),
      .arst_n(arst_n), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .event_input(event_input),
      .battery_mode(battery_mode), .time_now(time_now),
      .counter_halt(counter_halt), .pull_enable(pull_enable),
      .clock_write(clock_write));
   rtcev_host_model #(.DEV_ADDR(DA)) host (.clk(clk), .dev_oe(sda_oe),
      .scl(scl), .sda_wire(sda));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic stop_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string n, input logic [16:0] s,
                        input logic [16:0] e);
      compares++;
      if (s !== e)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic expect_v(input string n, input logic [16:0] v);
      name_q.push_back(n);
      note_q.push_back(v);
   endtask

   task automatic post(input logic [16:0] v);
      seen_v = v;
      ->seen_ev;
      // Waiting for an edge keeps every later stimulus at the same offset.
      tick(1);
   endtask

   task automatic lvl(input string n, input logic v, input logic e);
      expect_v(n, {16'h0000, e});
      post({16'h0000, v});
   endtask

   task automatic rd(input logic [7:0] a, input int n,
                     input rtcev_pkg::rtcev_bytes_t e);
      for (int i = 0; i < n; i++)
         expect_v($sformatf("reg %h", a + 8'(i)), {9'h000, e[i]});
      host.read_regs(a, n, rb);
      for (int i = 0; i < n; i++)
         post({9'h000, rb[i]});
   endtask

   // Level held for hi cycles, then a 6-cycle quiet gap, which clears the filter when sampling is bypassed.
   task automatic pulse_event(input int hi);
      event_input = 1'b1;
      tick(hi);
      event_input = 1'b0;
      tick(6);
   endtask

   initial
   begin
      forever
      begin
         @(seen_ev);
         if (note_q.size() == 0)
            check("unplanned result", seen_v, 17'h1ffff);
         else
            check(name_q.pop_front(), seen_v, note_q.pop_front());
      end
   end

   initial
   begin
      forever
      begin
         @(posedge clk);
         #1;
         if (clock_write.wr === 1'b1)
            post(clock_write);
      end
   end

   initial
   begin
      repeat (90000) @(posedge clk);
      miscompares++;
      $display("watchdog expired before the tests ended");
      stop_test();
   end

   initial
   begin
      void'($urandom(24));
      arst_n = 1'b0;
      event_input = 1'b0;
      battery_mode = 1'b0;
      t1 = 48'({$urandom(), $urandom()});
      t2 = 48'({$urandom(), $urandom()});
      t3 = 48'({$urandom(), $urandom()});
      time_now = t1;
      tick(20);
      arst_n = 1'b1;
      tick(4);
      lvl("counter_halt", counter_halt, 1'b0);
      lvl("pull_enable", pull_enable, 1'b1);
      lvl("sda_out", sda_out, 1'b0);
      rd(rtcev_pkg::ADDR_CFG, 1, 48'h0);
      c = 8'($urandom());
      host.write_reg(rtcev_pkg::ADDR_CFG, c);
      rd(rtcev_pkg::ADDR_CFG, 1, {40'h0, c & rtcev_pkg::CFG_WMASK});
      host.write_reg(rtcev_pkg::ADDR_CFG, 8'h80);
      lvl("pull_enable", pull_enable, 1'b0);
      host.write_reg(rtcev_pkg::ADDR_CFG, 8'h20);
      pulse_event(6);
      lvl("counter_halt", counter_halt, 1'b1);
      rd(rtcev_pkg::ADDR_STATUS, 1, 48'h10);
      time_now = t2;
      pulse_event(6);
      rd(rtcev_pkg::ADDR_STAMP_FIRST, 6, t1);
      expect_v("clock_write", {1'b1, 8'h00, c});
      host.write_reg(rtcev_pkg::ADDR_TIME_FIRST, c);
      lvl("counter_halt", counter_halt, 1'b0);
      host.write_reg(rtcev_pkg::ADDR_STATUS, 8'h00);
      host.write_reg(rtcev_pkg::ADDR_STAMP_FIRST, 8'hff);
      rd(rtcev_pkg::ADDR_STAMP_FIRST, 6, t1);
      rd(8'h30, 1, 48'h0);
      pulse_event(6);
      rd(rtcev_pkg::ADDR_STAMP_FIRST, 6, t2);
      lvl("counter_halt", counter_halt, 1'b1);
      host.write_reg(rtcev_pkg::ADDR_STATUS, 8'h00);
      host.write_reg(rtcev_pkg::ADDR_CFG, 8'h03);
      pulse_event(3);
      rd(rtcev_pkg::ADDR_STATUS, 1, 48'h10);
      host.write_reg(rtcev_pkg::ADDR_STATUS, 8'h00);
      host.write_reg(rtcev_pkg::ADDR_CFG, 8'h0d);
      time_now = t3;
      pulse_event(20);
      rd(rtcev_pkg::ADDR_STATUS, 1, 48'h0);
      pulse_event(200);
      rd(rtcev_pkg::ADDR_STATUS, 1, 48'h10);
      rd(rtcev_pkg::ADDR_STAMP_FIRST, 6, t3);
      // Codes 1 and 2 run at their full periods, so these pulses are long.
      host.write_reg(rtcev_pkg::ADDR_STATUS, 8'h00);
      host.write_reg(rtcev_pkg::ADDR_CFG, 8'h06);
      pulse_event(1100);
      rd(rtcev_pkg::ADDR_STATUS, 1, 48'h10);
      host.write_reg(rtcev_pkg::ADDR_STATUS, 8'h00);
      host.write_reg(rtcev_pkg::ADDR_CFG, 8'h0b);
      pulse_event(20100);
      rd(rtcev_pkg::ADDR_STATUS, 1, 48'h10);
      host.write_reg(rtcev_pkg::ADDR_STATUS, 8'h00);
      host.write_reg(rtcev_pkg::ADDR_CFG, 8'h40);
      battery_mode = 1'b1;
      tick(4);
      pulse_event(6);
      battery_mode = 1'b0;
      rd(rtcev_pkg::ADDR_STATUS, 1, 48'h0);
      host.write_reg(rtcev_pkg::ADDR_CFG, 8'h00);
      time_now = t1;
      battery_mode = 1'b1;
      tick(4);
      pulse_event(6);
      battery_mode = 1'b0;
      rd(rtcev_pkg::ADDR_STATUS, 1, 48'h10);
      rd(rtcev_pkg::ADDR_STAMP_FIRST, 6, t1);
      tick(10);
      stop_test();
   end
endmodule
